// ### cpc_active_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cpc_active_if;
  logic [7:0] pllCtl;
  logic [7:0] antibacklash;
  logic [7:0] distSrc;
  logic [7:0] pumpCurrent;

  modport producer (output pllCtl, output antibacklash, output distSrc, output pumpCurrent);
  modport consumer (input pllCtl, input antibacklash, input distSrc, input pumpCurrent);
endinterface
`default_nettype wire

// ### cpc_clock_path_cfg.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpc_map.svh"
module cpc_clock_path_cfg (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // loop control
  output logic pllPowerDown,
  output logic pdNegative,
  output logic [1:0] antibacklashSel,
  output cpc_pkg::cpc_pump_e pumpMode,
  output logic [2:0] pumpCurrentStep,
  output logic [12:0] pumpCurrentUa,
  // distribution routing
  output logic divBypass,
  output cpc_pkg::cpc_src_e srcSel
);
  import cpc_pkg::*;

  // ==========================================================================
  // bus front end
  // ==========================================================================
  logic dpValid_reg;
  logic dpWrite_reg;
  logic [11:0] dpIndex_reg;
  logic addrAccept;
  logic [11:0] addrIndex;
  logic wrEn;
  logic [7:0] wrByte;
  logic applyNow;

  function automatic logic hits(input logic [11:0] idx, input logic [11:0] target);
    hits = (idx == target);
  endfunction

  assign addrAccept = hsel && htrans[1] && hready;
  assign addrIndex = haddr[13:2];
  assign wrEn = dpValid_reg && dpWrite_reg;
  assign wrByte = hwdata[7:0];
  // only the exact go value commits; anything else leaves the active copy alone
  assign applyNow = wrEn && hits(dpIndex_reg, `CPC_IDX_UPDATE) && (wrByte == `CPC_UPDATE_GO);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dpValid_reg <= 1'b0;
      dpWrite_reg <= 1'b0;
      dpIndex_reg <= 12'h000;
    end
    else
    begin
      dpValid_reg <= addrAccept;
      dpWrite_reg <= addrAccept && hwrite;
      if (addrAccept)
      begin
        dpIndex_reg <= addrIndex;
      end
    end
  end

  // zero-wait slave: every transfer completes in its first data cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // staging copy
  // ==========================================================================
  logic [7:0] pllCtl_reg;
  logic [7:0] pllCtl_next;
  logic [7:0] antibacklash_reg;
  logic [7:0] antibacklash_next;
  logic [7:0] distSrc_reg;
  logic [7:0] distSrc_next;
  logic [7:0] pumpCurrent_reg;
  logic [7:0] pumpCurrent_next;

  always_comb
  begin
    pllCtl_next = pllCtl_reg;
    antibacklash_next = antibacklash_reg;
    distSrc_next = distSrc_reg;
    pumpCurrent_next = pumpCurrent_reg;
    if (wrEn && hits(dpIndex_reg, `CPC_IDX_PLL_CTL))
    begin
      pllCtl_next = wrByte;
    end
    else if (wrEn && hits(dpIndex_reg, `CPC_IDX_ANTIBACKLASH))
    begin
      antibacklash_next = wrByte;
    end
    else if (wrEn && hits(dpIndex_reg, `CPC_IDX_DIST_SRC))
    begin
      distSrc_next = wrByte;
    end
    else if (wrEn && hits(dpIndex_reg, `CPC_IDX_PUMP_CURRENT))
    begin
      pumpCurrent_next = wrByte;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pllCtl_reg <= `CPC_RST_PLL_CTL;
      antibacklash_reg <= `CPC_RST_ABL;
      distSrc_reg <= `CPC_RST_DIST;
      pumpCurrent_reg <= `CPC_RST_CUR;
    end
    else
    begin
      // writes stage only; the loop sees nothing until the commit
      pllCtl_reg <= pllCtl_next;
      antibacklash_reg <= antibacklash_next;
      distSrc_reg <= distSrc_next;
      pumpCurrent_reg <= pumpCurrent_next;
    end
  end

  // ==========================================================================
  // active copy
  // ==========================================================================
  logic [7:0] pllCtlActive;
  logic [7:0] antibacklashActive;
  logic [7:0] distSrcActive;
  logic [7:0] pumpCurrentActive;
  cpc_active_if act ();

  cpc_stage_reg #(.WIDTH(8), .RESET_VALUE(`CPC_RST_PLL_CTL)) uPllCtl (
    .clock(clock),
    .srst(srst),
    .applyNow(applyNow),
    .staged(pllCtl_reg),
    .active(pllCtlActive)
  );

  cpc_stage_reg #(.WIDTH(8), .RESET_VALUE(`CPC_RST_ABL)) uAntibacklash (
    .clock(clock),
    .srst(srst),
    .applyNow(applyNow),
    .staged(antibacklash_reg),
    .active(antibacklashActive)
  );

  cpc_stage_reg #(.WIDTH(8), .RESET_VALUE(`CPC_RST_DIST)) uDistSrc (
    .clock(clock),
    .srst(srst),
    .applyNow(applyNow),
    .staged(distSrc_reg),
    .active(distSrcActive)
  );

  cpc_stage_reg #(.WIDTH(8), .RESET_VALUE(`CPC_RST_CUR)) uPumpCurrent (
    .clock(clock),
    .srst(srst),
    .applyNow(applyNow),
    .staged(pumpCurrent_reg),
    .active(pumpCurrentActive)
  );

  assign act.pllCtl = pllCtlActive;
  assign act.antibacklash = antibacklashActive;
  assign act.distSrc = distSrcActive;
  assign act.pumpCurrent = pumpCurrentActive;

  cpc_mode_decode uDecode (
    .clock(clock),
    .srst(srst),
    .act(act),
    .pllPowerDown(pllPowerDown),
    .pdNegative(pdNegative),
    .antibacklashSel(antibacklashSel),
    .pumpMode(pumpMode),
    .pumpCurrentStep(pumpCurrentStep),
    .pumpCurrentUa(pumpCurrentUa),
    .divBypass(divBypass),
    .srcSel(srcSel)
  );

  // ==========================================================================
  // read path
  // ==========================================================================
  logic [7:0] pllCtlActNext;
  logic [7:0] ablActNext;
  logic [7:0] distActNext;
  logic [7:0] curActNext;
  logic [31:0] rdValue;

  // next values forward a commit landing on the same edge
  assign pllCtlActNext = applyNow ? pllCtl_reg : pllCtlActive;
  assign ablActNext = applyNow ? antibacklash_reg : antibacklashActive;
  assign distActNext = applyNow ? distSrc_reg : distSrcActive;
  assign curActNext = applyNow ? pumpCurrent_reg : pumpCurrentActive;

  always_comb
  begin
    rdValue = 32'h0000_0000;
    if (hits(addrIndex, `CPC_IDX_PLL_CTL))
    begin
      rdValue = {24'h00_0000, pllCtl_next};
    end
    else if (hits(addrIndex, `CPC_IDX_ANTIBACKLASH))
    begin
      rdValue = {24'h00_0000, antibacklash_next};
    end
    else if (hits(addrIndex, `CPC_IDX_DIST_SRC))
    begin
      rdValue = {24'h00_0000, distSrc_next};
    end
    else if (hits(addrIndex, `CPC_IDX_PUMP_CURRENT))
    begin
      rdValue = {24'h00_0000, pumpCurrent_next};
    end
    else if (hits(addrIndex, `CPC_IDX_ACTIVE_STATUS))
    begin
      rdValue = {curActNext, ablActNext, distActNext, pllCtlActNext};
    end
  end

  // update register is a strobe and reads back zero, as do holes
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (addrAccept && !hwrite)
    begin
      hrdata <= rdValue;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  a_commit_all_copies: assert property (applyNow |=> (pllCtlActive == $past(pllCtl_reg)) &&
    (antibacklashActive == $past(antibacklash_reg)) && (distSrcActive == $past(distSrc_reg)) &&
    (pumpCurrentActive == $past(pumpCurrent_reg)))
  else $error("staged values did not commit together");

  a_hold_until_go: assert property (!applyNow |=> $stable(pllCtlActive) && $stable(distSrcActive) &&
    $stable(antibacklashActive) && $stable(pumpCurrentActive))
  else $error("active copy changed without an update write");

  a_power_state_follows: assert property ((pllCtlActive[1:0] == `CPC_PWR_DOWN) |=> pllPowerDown)
  else $error("loop not powered down for code 01b");

  a_power_normal_runs: assert property ((pllCtlActive[1:0] == `CPC_PWR_NORMAL) |=> !pllPowerDown)
  else $error("loop held down for code 00b");

  a_divider_bypass_set: assert property (distSrcActive[0] |=> divBypass)
  else $error("divider not bypassed");

  a_divider_used_clear: assert property (!distSrcActive[0] |=> !divBypass)
  else $error("divider bypassed while bit clear");

  a_source_ext_clk: assert property (!distSrcActive[1] |=> (srcSel == CPC_SRC_EXT_CLK))
  else $error("external clock not selected");

  a_source_osc: assert property (distSrcActive[1] |=> (srcSel == CPC_SRC_OSC))
  else $error("oscillator not selected");

  a_polarity_tracks: assert property (##1 (pdNegative == $past(pllCtlActive[7])))
  else $error("polarity does not follow control bit 7");

  a_backlash_width: assert property (##1 (antibacklashSel == $past(antibacklashActive[1:0])))
  else $error("anti-backlash width mismatch");

  a_pump_normal_mode: assert property ((pllCtlActive[6:4] == `CPC_PUMP_CODE_NORMAL) |=>
    (pumpMode == CPC_PUMP_NORMAL))
  else $error("pump not in normal mode");

  a_pump_current_ua: assert property (applyNow ##1 1'b1 |=> (pumpCurrentUa ==
    13'(`CPC_PUMP_LSB_UA * (13'($past(pumpCurrent_reg[2:0], 2)) + 13'h0001))))
  else $error("pump current not 600 uA per step");

  a_go_to_output: assert property (applyNow && (pllCtl_reg[1:0] == `CPC_PWR_NORMAL) |-> ##2 !pllPowerDown)
  else $error("committed power-up not seen two cycles later");

  a_bad_go_ignored: assert property (wrEn && hits(dpIndex_reg, `CPC_IDX_UPDATE) &&
    (wrByte != `CPC_UPDATE_GO) |=> $stable(pllCtlActive) && $stable(distSrcActive))
  else $error("update write of a wrong code committed");

  a_update_reads_zero: assert property (addrAccept && !hwrite && hits(addrIndex, `CPC_IDX_UPDATE) |=>
    (hrdata == 32'h0000_0000))
  else $error("update register did not read back zero");

  a_stage_write_lands: assert property (wrEn && hits(dpIndex_reg, `CPC_IDX_PLL_CTL) |=>
    (pllCtl_reg == $past(wrByte)))
  else $error("control write did not reach the staging copy");

  a_dist_write_lands: assert property (wrEn && hits(dpIndex_reg, `CPC_IDX_DIST_SRC) |=>
    (distSrc_reg == $past(wrByte)))
  else $error("distribution write did not reach the staging copy");

  a_bus_always_ready: assert property (!$past(srst) |-> hreadyout && !hresp)
  else $error("bus stalled or answered with an error");

  // forced pump codes are test modes; each decode arm gets its own check
  a_pump_up_mode: assert property ((pllCtlActive[6:4] == `CPC_PUMP_CODE_UP) |=> (pumpMode == CPC_PUMP_UP))
  else $error("pump not forced up");

  a_pump_down_mode: assert property ((pllCtlActive[6:4] == `CPC_PUMP_CODE_DOWN) |=> (pumpMode == CPC_PUMP_DOWN))
  else $error("pump not forced down");

  a_pump_highz_mode: assert property ((pllCtlActive[6:4] == `CPC_PUMP_CODE_HIGHZ) || pllCtlActive[6] |=>
    (pumpMode == CPC_PUMP_HIGHZ))
  else $error("pump not floated for an idle code");

  a_pump_step_tracks: assert property (##1 (pumpCurrentStep == $past(pumpCurrentActive[2:0])))
  else $error("pump current step does not follow the active copy");

  c_commit_seen: cover property (applyNow);
  c_loop_running: cover property (applyNow ##2 !pllPowerDown);
  c_osc_source: cover property (srcSel == CPC_SRC_OSC && divBypass == 1'b0);
  c_status_read: cover property (addrAccept && !hwrite && hits(addrIndex, `CPC_IDX_ACTIVE_STATUS));
  c_pump_forced: cover property (pumpMode == CPC_PUMP_UP || pumpMode == CPC_PUMP_DOWN);
endmodule
`default_nettype wire

// ### cpc_map.svh
// How it works
// - Power field 01b powers the loop down two edges after the commit; 00b runs it normally.
// - Distribution bit 0 set bypasses the oscillator divider.
// - Distribution bit 1 clear takes the external clock input as source.
// - Control bit 7 picks detector polarity: 0 positive, 1 negative.
// - Nothing takes effect until software writes 0x01 to the update register.
// - Anti-backlash pulse width comes from bits 1 to 0 of its register.
// - Three-bit pump mode picks high impedance, normal, pump-up or pump-down.
// - Pump current has eight steps from 600 uA to 4.8 mA.
// - Distribution bit 0 clear routes the source through the divider.
// - Distribution bit 1 set selects the on-chip oscillator.
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

// register indices; byte address is four times the index
`define CPC_IDX_PLL_CTL 12'h010
`define CPC_IDX_ANTIBACKLASH 12'h017
`define CPC_IDX_DIST_SRC 12'h1E1
`define CPC_IDX_UPDATE 12'h232
`define CPC_IDX_PUMP_CURRENT 12'h0F0
`define CPC_IDX_ACTIVE_STATUS 12'h0F1

// field positions
`define CPC_PWR_LSB 0
`define CPC_PWR_MSB 1
`define CPC_PUMP_MODE_LSB 4
`define CPC_PUMP_MODE_MSB 6
`define CPC_POLARITY_BIT 7
`define CPC_ABL_MSB 1
`define CPC_DIST_BYPASS_BIT 0
`define CPC_DIST_OSC_BIT 1
`define CPC_CUR_MSB 2

// field values
`define CPC_PWR_NORMAL 2'h0
`define CPC_PWR_DOWN 2'h1
`define CPC_UPDATE_GO 8'h01
`define CPC_PUMP_CODE_HIGHZ 3'h0
`define CPC_PUMP_CODE_UP 3'h1
`define CPC_PUMP_CODE_DOWN 3'h2
`define CPC_PUMP_CODE_NORMAL 3'h3
`define CPC_PUMP_LSB_UA 13'h0258

// reset values
`define CPC_RST_PLL_CTL 8'h01
`define CPC_RST_ABL 8'h00
`define CPC_RST_DIST 8'h00
`define CPC_RST_CUR 8'h07

`endif

// ### cpc_mode_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpc_map.svh"
module cpc_mode_decode (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // active configuration
  cpc_active_if.consumer act,
  // loop control
  output logic pllPowerDown,
  output logic pdNegative,
  output logic [1:0] antibacklashSel,
  output cpc_pkg::cpc_pump_e pumpMode,
  output logic [2:0] pumpCurrentStep,
  output logic [12:0] pumpCurrentUa,
  // distribution routing
  output logic divBypass,
  output cpc_pkg::cpc_src_e srcSel
);
  import cpc_pkg::*;

  function automatic cpc_pump_e pumpOf(input logic [7:0] ctl);
    case (ctl[`CPC_PUMP_MODE_MSB:`CPC_PUMP_MODE_LSB])
      `CPC_PUMP_CODE_NORMAL: pumpOf = CPC_PUMP_NORMAL;
      `CPC_PUMP_CODE_UP: pumpOf = CPC_PUMP_UP;
      `CPC_PUMP_CODE_DOWN: pumpOf = CPC_PUMP_DOWN;
      // unused codes float the pump, the safest state for the loop
      default: pumpOf = CPC_PUMP_HIGHZ;
    endcase
  endfunction

  function automatic logic [12:0] uaOf(input logic [7:0] cur);
    uaOf = 13'(`CPC_PUMP_LSB_UA * (13'(cur[`CPC_CUR_MSB:0]) + 13'h0001));
  endfunction

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pllPowerDown <= 1'b1;
      pdNegative <= 1'b0;
      antibacklashSel <= 2'h0;
      pumpMode <= pumpOf(`CPC_RST_PLL_CTL);
    end
    else
    begin
      // only 00b runs the loop; any other code keeps it down
      pllPowerDown <= (act.pllCtl[`CPC_PWR_MSB:`CPC_PWR_LSB] != `CPC_PWR_NORMAL);
      pdNegative <= act.pllCtl[`CPC_POLARITY_BIT];
      antibacklashSel <= act.antibacklash[`CPC_ABL_MSB:0];
      pumpMode <= pumpOf(act.pllCtl);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pumpCurrentStep <= 3'(`CPC_RST_CUR);
      pumpCurrentUa <= uaOf(`CPC_RST_CUR);
    end
    else
    begin
      pumpCurrentStep <= act.pumpCurrent[`CPC_CUR_MSB:0];
      pumpCurrentUa <= uaOf(act.pumpCurrent);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      divBypass <= 1'b0;
      srcSel <= CPC_SRC_EXT_CLK;
    end
    else
    begin
      divBypass <= act.distSrc[`CPC_DIST_BYPASS_BIT];
      srcSel <= cpc_src_e'(act.distSrc[`CPC_DIST_OSC_BIT]);
    end
  end
endmodule
`default_nettype wire

// ### cpc_pkg.sv
`default_nettype none
package cpc_pkg;
  typedef enum logic [1:0] {
    CPC_PUMP_HIGHZ = 2'b00,
    CPC_PUMP_NORMAL = 2'b01,
    CPC_PUMP_UP = 2'b10,
    CPC_PUMP_DOWN = 2'b11
  } cpc_pump_e;

  typedef enum logic {
    CPC_SRC_EXT_CLK = 1'b0,
    CPC_SRC_OSC = 1'b1
  } cpc_src_e;
endpackage
`default_nettype wire

// ### cpc_stage_reg.sv
`timescale 1ns/1ns
`default_nettype none
module cpc_stage_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // staging side
  input wire logic applyNow,
  input wire logic [WIDTH-1:0] staged,
  // active side
  output logic [WIDTH-1:0] active
);
  import cpc_pkg::*;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      active <= RESET_VALUE;
    end
    else if (applyNow)
    begin
      active <= staged;
    end
  end
endmodule
`default_nettype wire

// ### cpc_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpc_map.svh"
module testbench;
  import cpc_pkg::*;
  // ==========================================
  // signals
  logic clock;
  logic srst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pllPowerDown;
  logic pdNegative;
  logic [1:0] antibacklashSel;
  cpc_pump_e pumpMode;
  logic [2:0] pumpCurrentStep;
  logic [12:0] pumpCurrentUa;
  logic divBypass;
  cpc_src_e srcSel;
  int mismatches;
  int checks;

  cpc_clock_path_cfg dut (
    .clock(clock),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .pllPowerDown(pllPowerDown),
    .pdNegative(pdNegative),
    .antibacklashSel(antibacklashSel),
    .pumpMode(pumpMode),
    .pumpCurrentStep(pumpCurrentStep),
    .pumpCurrentUa(pumpCurrentUa),
    .divBypass(divBypass),
    .srcSel(srcSel)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================
  // reporting
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ==========================================
  // ahb-lite master
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        mismatches++;
        $display("BAD %0t bus wait ran out", $time);
        end_of_test();
      end
      @(posedge clock);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {18'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000, "response not okay");
  endtask

  task automatic wr_reg(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, {24'h00_0000, d}, dummy);
  endtask

  task automatic rd_reg(input logic [11:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] got;
    bus(1'b0, idx, 32'h0000_0000, got);
    chk(got, exp, what);
  endtask

  // ==========================================
  // expectations
  // own pump code table: 0 highZ, 1 up, 2 down, 3 normal, rest highZ
  function automatic cpc_pump_e pump_of(input logic [2:0] c);
    case (c)
      3'h1: return CPC_PUMP_UP;
      3'h2: return CPC_PUMP_DOWN;
      3'h3: return CPC_PUMP_NORMAL;
      default: return CPC_PUMP_HIGHZ;
    endcase
  endfunction

  // outputs move one edge after the active copy; three edges leave margin
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic chk_out(input logic [10:0] exp, input string what);
    chk(32'({pllPowerDown, pdNegative, antibacklashSel, pumpMode, pumpCurrentStep, divBypass, srcSel}),
        32'(exp), what);
  endtask

  // ==========================================
  // scenarios
  task automatic test_reset();
    chk_out({1'b1, 1'b0, 2'b00, CPC_PUMP_HIGHZ, 3'h7, 1'b0, CPC_SRC_EXT_CLK}, "reset outputs");
    chk(32'(pumpCurrentUa), 32'h0000_12C0, "reset pump current");
    rd_reg(`CPC_IDX_PLL_CTL, 32'h0000_0001, "reset control");
    rd_reg(`CPC_IDX_ANTIBACKLASH, 32'h0000_0000, "reset antibacklash");
    rd_reg(`CPC_IDX_DIST_SRC, 32'h0000_0000, "reset distribution");
    rd_reg(`CPC_IDX_PUMP_CURRENT, 32'h0000_0007, "reset current");
    rd_reg(`CPC_IDX_UPDATE, 32'h0000_0000, "update reads zero");
    rd_reg(12'h3FF, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask

  task automatic test_staging();
    wr_reg(`CPC_IDX_PLL_CTL, 8'h00);
    wr_reg(`CPC_IDX_DIST_SRC, 8'h01);
    wr_reg(12'h3FF, 8'hA5);
    rd_reg(12'h3FF, 32'h0000_0000, "unmapped write ignored");
    rd_reg(`CPC_IDX_DIST_SRC, 32'h0000_0001, "staged readback");
    settle();
    chk_out({1'b1, 1'b0, 2'b00, CPC_PUMP_HIGHZ, 3'h7, 1'b0, CPC_SRC_EXT_CLK}, "staged not applied");
    rd_reg(`CPC_IDX_ACTIVE_STATUS, 32'h0700_0001, "active before update");
    // a wrong update code must not commit
    wr_reg(`CPC_IDX_UPDATE, 8'h02);
    settle();
    chk_out({1'b1, 1'b0, 2'b00, CPC_PUMP_HIGHZ, 3'h7, 1'b0, CPC_SRC_EXT_CLK}, "bad update code");
    wr_reg(`CPC_IDX_UPDATE, `CPC_UPDATE_GO);
    settle();
    chk_out({1'b0, 1'b0, 2'b00, CPC_PUMP_HIGHZ, 3'h7, 1'b1, CPC_SRC_EXT_CLK}, "update applied");
    $display("test staging done");
  endtask

  task automatic test_modes();
    logic [2:0] c;
    logic [7:0] ctl;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      ctl = {c[0], c, 2'b00, c[1:0]};
      // calibration lives with the oscillator, outside this block; the bench never starts one
      wr_reg(`CPC_IDX_PLL_CTL, ctl);
      rd_reg(`CPC_IDX_PLL_CTL, {24'h00_0000, ctl}, "read after write");
      wr_reg(`CPC_IDX_ANTIBACKLASH, {6'h00, c[1:0]});
      wr_reg(`CPC_IDX_DIST_SRC, {6'h00, c[2:1]});
      wr_reg(`CPC_IDX_PUMP_CURRENT, {5'h00, c});
      wr_reg(`CPC_IDX_UPDATE, `CPC_UPDATE_GO);
      settle();
      chk_out({c[1:0] != 2'b00, c[0], c[1:0], pump_of(c), c, c[1], cpc_src_e'(c[2])},
              "mode outputs");
      chk(32'(pumpCurrentUa), 32'(600 * (i + 1)), "pump current");
      rd_reg(`CPC_IDX_ACTIVE_STATUS, {5'h00, c, 6'h00, c[1:0], 6'h00, c[2:1], ctl}, "active status");
    end
    $display("test modes done");
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    mismatches = 0;
    checks = 0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    test_reset();
    test_staging();
    test_modes();
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("BAD %0t run limit reached", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
